// [shared/mr45_defines.vh]
// constants for the mode register four/five feature logic
`ifndef MR45_DEFINES_VH
`define MR45_DEFINES_VH
`define MRSEL_MR1 3'h1
`define MRSEL_MR2 3'h2
`define MRSEL_MR4 3'h4
`define MRSEL_MR5 3'h5
`define MRSEL_RSVD 3'h7
`define MR1_NOM_LO 2
`define MR1_NOM_MID 6
`define MR1_NOM_HI 9
`define MR2_LPASR_LO 6
`define MR2_LPASR_HI 7
`define MR2_CRC_BIT 12
`define MR4_MPS_BIT 1
`define MR4_TCR_BIT 3
`define MR4_CAL_LO 6
`define MR4_CAL_HI 8
`define MR4_PRE_TRAIN_BIT 10
`define MR4_RPRE_BIT 11
`define MR4_WPRE_BIT 12
`define MR5_PL_LO 0
`define MR5_PL_HI 2
`define MR5_CRC_ERR_BIT 3
`define MR5_PAR_ERR_BIT 4
`define MR5_ODT_PD_BIT 5
`define MR5_PERSIST_BIT 9
`define MR5_DM_BIT 10
`define MR5_WDBI_BIT 11
`define MR5_RDBI_BIT 12
`define MR_RESET_VAL 18'h00000
`define PIN_SYNC_IDLE 29'h1FFFFFFF
`endif

// [verilog/mr45_feature_ctrl.v]
// mode register four/five feature logic of the memory device
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "mr45_defines.vh"
module mr45_feature_ctrl (
  input wire SYS_CLK,
  input wire NRST,
  input wire CS_N,
  input wire ACT_N,
  input wire [2:0] CMD_LINES,
  input wire [17:0] ADDR,
  input wire [1:0] BA,
  input wire [1:0] BG,
  input wire PAR_IN,
  input wire IS_X4,
  input wire MRS_STROBE,
  input wire MPS_EXIT,
  input wire CRC_FAIL,
  input wire POWER_DOWN,
  input wire WRITE_BURST,
  input wire ODT_PIN,
  output reg CMD_VALID,
  output reg [17:0] CMD_ADDR,
  output reg [2:0] CMD_CODE,
  output reg CMD_ACT_N,
  output reg [1:0] CMD_BA,
  output reg [1:0] CMD_BG,
  output reg WPRE_2CK,
  output reg RPRE_2CK,
  output reg PRE_TRAIN,
  output reg TCR_ACTIVE,
  output reg MPS_ACTIVE,
  output reg PARITY_ERR,
  output reg CRC_ERR,
  output reg DM_ACTIVE,
  output reg WDBI_ACTIVE,
  output reg RDBI_ACTIVE,
  output reg NOM_TERM_EN,
  output reg [3:0] WR_BURST_UI
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [28:0] s1_ff;
  reg [28:0] s2_ff;
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      s1_ff <= `PIN_SYNC_IDLE;
      s2_ff <= `PIN_SYNC_IDLE;
    end else begin
      s1_ff <= {CS_N, ACT_N, CMD_LINES, ADDR, BA, BG, PAR_IN, MRS_STROBE};
      s2_ff <= s1_ff;
    end
  end

  reg [5:0] s1b_ff;
  reg [5:0] s2b_ff;
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      s1b_ff <= 6'h00;
      s2b_ff <= 6'h00;
    end else begin
      s1b_ff <= {IS_X4, MPS_EXIT, CRC_FAIL, POWER_DOWN, WRITE_BURST, ODT_PIN};
      s2b_ff <= s1b_ff;
    end
  end

  wire cs_n = s2_ff[28];
  wire act_n = s2_ff[27];
  wire [2:0] cmd = s2_ff[26:24];
  wire [17:0] addr = s2_ff[23:6];
  wire [1:0] ba = s2_ff[5:4];
  wire [1:0] bg = s2_ff[3:2];
  wire par = s2_ff[1];
  wire is_mrs = s2_ff[0];
  wire is_x4 = s2b_ff[5];
  wire mps_exit = s2b_ff[4];
  wire crc_fail = s2b_ff[3];
  wire pdown = s2b_ff[2];
  wire wr_burst = s2b_ff[1];
  wire odt = s2b_ff[0];

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function [3:0] cal_clocks;
    input [2:0] code;
    begin
      case (code)
        3'h1: cal_clocks = 4'h3;
        3'h2: cal_clocks = 4'h4;
        3'h3: cal_clocks = 4'h5;
        3'h4: cal_clocks = 4'h6;
        3'h5: cal_clocks = 4'h8;
        default: cal_clocks = 4'h0;
      endcase
    end
  endfunction
  function parity_bad;
    input a_n;
    input [2:0] c;
    input [17:0] a;
    input [1:0] b;
    input [1:0] g;
    input p;
    begin
      parity_bad = ^{a_n, c, a, b, g, p};
    end
  endfunction

  // ----------------------------------------------------------------
  // mode register state
  // ----------------------------------------------------------------
  reg [17:0] mr1_ff;
  reg [17:0] mr2_ff;
  reg [17:0] mr4_ff;
  reg [17:0] mr5_ff;
  reg par_err_ff;
  reg crc_err_ff;
  // ----------------------------------------------------------------
  // command delay sequencing
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [1:0] st_ff;
  reg [3:0] cnt_ff;
  reg [1:0] nxt_st;
  reg [3:0] nxt_cnt;

  wire [2:0] mr_sel = {bg[0], ba};
  wire [3:0] cal = cal_clocks(mr4_ff[`MR4_CAL_HI:`MR4_CAL_LO]);
  wire cal_on = (cal != 4'h0);
  wire par_on = (mr5_ff[`MR5_PL_HI:`MR5_PL_LO] != 3'h0);
  wire check_on = par_on && (!par_err_ff || mr5_ff[`MR5_PERSIST_BIT]);
  wire mps_on = mr4_ff[`MR4_MPS_BIT];
  wire nom_off = ({mr1_ff[`MR1_NOM_HI], mr1_ff[`MR1_NOM_MID], mr1_ff[`MR1_NOM_LO]} == 3'h0);

  // command strobe: chip select low now (no delay) or delay expired
  wire cs_hit = !cs_n;
  wire fire = cal_on ? (st_ff == ST_WAIT && cnt_ff == 4'h1) : cs_hit;
  wire perr = check_on && parity_bad(act_n, cmd, addr, ba, bg, par);
  // max power saving blocks every command until exit; parity errors are still flagged
  wire accept = fire && !perr && !mps_on;
  wire mrs_ok = accept && is_mrs && (mr_sel != `MRSEL_RSVD);

  always @* begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_IDLE: begin
        if (cal_on && cs_hit) begin
          nxt_st = ST_WAIT;
          nxt_cnt = cal;
        end
      end
      ST_WAIT: begin
        if (cnt_ff == 4'h1) begin
          nxt_st = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
        nxt_cnt = 4'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // mode register writes
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      mr1_ff <= `MR_RESET_VAL;
      mr2_ff <= `MR_RESET_VAL;
      mr4_ff <= `MR_RESET_VAL;
      mr5_ff <= `MR_RESET_VAL;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      if (mps_on && mps_exit) begin
        mr4_ff[`MR4_MPS_BIT] <= 1'b0;
      end
      if (mrs_ok) begin
        case (mr_sel)
          `MRSEL_MR1: mr1_ff <= addr;
          `MRSEL_MR2: mr2_ff <= addr;
          `MRSEL_MR4: mr4_ff <= addr;
          `MRSEL_MR5: begin
            mr5_ff <= addr;
            if (nom_off) begin
              mr5_ff[`MR5_ODT_PD_BIT] <= mr5_ff[`MR5_ODT_PD_BIT];
            end
            if (!is_x4 && addr[`MR5_DM_BIT] && (addr[`MR5_WDBI_BIT] || addr[`MR5_RDBI_BIT])) begin
              mr5_ff[`MR5_DM_BIT] <= 1'b0;
            end
          end
          default: mr1_ff <= mr1_ff;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky error status
  // ----------------------------------------------------------------
  wire mr5_wr = mrs_ok && (mr_sel == `MRSEL_MR5);
  wire par_set = perr;
  wire par_clr = mr5_wr && !addr[`MR5_PAR_ERR_BIT];
  wire crc_set = crc_fail && mr2_ff[`MR2_CRC_BIT];
  wire crc_clr = mr5_wr && !addr[`MR5_CRC_ERR_BIT];

  // set wins over clear
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      par_err_ff <= 1'b0;
      crc_err_ff <= 1'b0;
    end else begin
      if (par_set) begin
        par_err_ff <= 1'b1;
      end else if (par_clr) begin
        par_err_ff <= 1'b0;
      end
      if (crc_set) begin
        crc_err_ff <= 1'b1;
      end else if (crc_clr) begin
        crc_err_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      CMD_VALID <= 1'b0;
      CMD_ADDR <= 18'h00000;
      CMD_CODE <= 3'h7;
      CMD_ACT_N <= 1'b1;
      CMD_BA <= 2'h0;
      CMD_BG <= 2'h0;
      WPRE_2CK <= 1'b0;
      RPRE_2CK <= 1'b0;
      PRE_TRAIN <= 1'b0;
      TCR_ACTIVE <= 1'b0;
      MPS_ACTIVE <= 1'b0;
      PARITY_ERR <= 1'b0;
      CRC_ERR <= 1'b0;
      DM_ACTIVE <= 1'b0;
      WDBI_ACTIVE <= 1'b0;
      RDBI_ACTIVE <= 1'b0;
      NOM_TERM_EN <= 1'b0;
      WR_BURST_UI <= 4'h8;
    end else begin
      CMD_VALID <= accept && !(is_mrs && mr_sel == `MRSEL_RSVD);
      CMD_ADDR <= addr;
      CMD_CODE <= cmd;
      CMD_ACT_N <= act_n;
      CMD_BA <= ba;
      CMD_BG <= bg;
      WPRE_2CK <= mr4_ff[`MR4_WPRE_BIT];
      RPRE_2CK <= mr4_ff[`MR4_RPRE_BIT];
      PRE_TRAIN <= mr4_ff[`MR4_PRE_TRAIN_BIT];
      TCR_ACTIVE <= mr4_ff[`MR4_TCR_BIT] && (mr2_ff[`MR2_LPASR_HI:`MR2_LPASR_LO] == 2'h3);
      MPS_ACTIVE <= mps_on;
      PARITY_ERR <= par_err_ff;
      CRC_ERR <= crc_err_ff;
      DM_ACTIVE <= !is_x4 && mr5_ff[`MR5_DM_BIT] && wr_burst;
      WDBI_ACTIVE <= !is_x4 && mr5_ff[`MR5_WDBI_BIT] && !mr5_ff[`MR5_DM_BIT];
      RDBI_ACTIVE <= !is_x4 && mr5_ff[`MR5_RDBI_BIT];
      NOM_TERM_EN <= !nom_off && odt && !(pdown && !mr5_ff[`MR5_ODT_PD_BIT]);
      WR_BURST_UI <= mr2_ff[`MR2_CRC_BIT] ? 4'hA : 4'h8;
    end
  end
endmodule

// [dv/mr45_ctrl_model.sv]
// controller model driving the command and address pins
`timescale 1ns/10ps
module mr45_ctrl_model (
  input wire SYS_CLK,
  output reg CS_N,
  output reg ACT_N,
  output reg [2:0] CMD_LINES,
  output reg [17:0] ADDR,
  output reg [1:0] BA,
  output reg [1:0] BG,
  output reg PAR_IN,
  output reg MRS_STROBE
);
  integer i;
  initial begin
    {CS_N, ACT_N, CMD_LINES, ADDR, BA, BG, PAR_IN, MRS_STROBE} = {2'h3, 27'h0};
  end
  // one command; fields follow chip select by dly clocks
  task send(input mode_register_set_cmd, input [2:0] sel, input [17:0] a, input flip, input [3:0] dly);
    for (i = 0; i <= dly; i = i + 1) begin
      @(negedge SYS_CLK);
      CS_N = (i != 0);
      MRS_STROBE = mode_register_set_cmd & (i == dly);
      ADDR = (i == dly) ? a : ~a;
      {BG, BA} = {1'b0, sel} ^ {4{i != dly}};
      CMD_LINES = mode_register_set_cmd ? 3'h0 : 3'h5;
      PAR_IN = ^{ACT_N, CMD_LINES, ADDR, BA, BG} ^ flip;
    end
    @(negedge SYS_CLK);
    {CS_N, MRS_STROBE} = 2'h2;
    {ADDR, BG, BA} = ~{ADDR, BG, BA};
  endtask
  // settling wait stretched while the internal reference monitor is on
  task vref_settle(input integer base_ns, input integer pf);
    repeat ((base_ns + 10 + 15 * pf + 7) / 8) @(negedge SYS_CLK);
  endtask
endmodule

// [dv/mr45_feature_ctrl_sva.sv]
// port checker for the mode register four/five feature logic
`timescale 1ns/10ps
module mr45_feature_ctrl_sva (
  input wire SYS_CLK,
  input wire NRST,
  input wire CS_N,
  input wire [1:0] BA,
  input wire [1:0] BG,
  input wire MRS_STROBE,
  input wire IS_X4,
  input wire CMD_VALID,
  input wire WPRE_2CK,
  input wire RPRE_2CK,
  input wire MPS_ACTIVE,
  input wire PARITY_ERR,
  input wire CRC_ERR,
  input wire DM_ACTIVE,
  input wire WDBI_ACTIVE,
  input wire RDBI_ACTIVE,
  input wire [3:0] WR_BURST_UI
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  AST_RSVD: assert property (!CS_N && MRS_STROBE && {BG[0], BA} == 3'h7 |-> ##3 !CMD_VALID)
    else $error("reserved select answered");
  AST_PRE: assert property ($changed({WPRE_2CK, RPRE_2CK}) |-> $past(CMD_VALID) || $past(CMD_VALID, 2))
    else $error("preamble changed without command");
  AST_DM_DBI: assert property (!(DM_ACTIVE && WDBI_ACTIVE))
    else $error("mask and inversion both on");
  AST_X4: assert property (IS_X4 && $past(IS_X4, 4) |-> !WDBI_ACTIVE && !RDBI_ACTIVE)
    else $error("inversion on x4");
  AST_CRC: assert property ($fell(CRC_ERR) |-> $past(CMD_VALID) || $past(CMD_VALID, 2))
    else $error("crc status cleared without command");
  AST_PAR: assert property ($fell(PARITY_ERR) |-> $past(CMD_VALID) || $past(CMD_VALID, 2))
    else $error("parity status cleared without command");
  AST_MPS: assert property (MPS_ACTIVE [*5] |-> !CMD_VALID)
    else $error("command taken in power saving");
  AST_UI: assert property (WR_BURST_UI == 4'h8 || WR_BURST_UI == 4'hA)
    else $error("bad burst length");
endmodule
bind mr45_feature_ctrl mr45_feature_ctrl_sva mr45_feature_ctrl_sva_i (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .CS_N(CS_N), .BA(BA), .BG(BG), .MRS_STROBE(MRS_STROBE), .IS_X4(IS_X4),
  .CMD_VALID(CMD_VALID), .WPRE_2CK(WPRE_2CK), .RPRE_2CK(RPRE_2CK), .MPS_ACTIVE(MPS_ACTIVE),
  .PARITY_ERR(PARITY_ERR), .CRC_ERR(CRC_ERR), .DM_ACTIVE(DM_ACTIVE), .WDBI_ACTIVE(WDBI_ACTIVE),
  .RDBI_ACTIVE(RDBI_ACTIVE), .WR_BURST_UI(WR_BURST_UI)
);

// [dv/mr45_feature_ctrl_tb_top.sv]
// self-checking bench for the mode register four/five feature logic
`timescale 1ns/10ps
module mr45_feature_ctrl_tb_top;
  reg SYS_CLK = 1'b0;
  reg NRST = 1'b0;
  reg IS_X4 = 1'b0, MPS_EXIT = 1'b0, CRC_FAIL = 1'b0, POWER_DOWN = 1'b0, WRITE_BURST = 1'b0, ODT_PIN = 1'b0;
  wire CS_N, ACT_N, PAR_IN, MRS_STROBE, CMD_VALID, WPRE_2CK, RPRE_2CK, PRE_TRAIN, TCR_ACTIVE, MPS_ACTIVE;
  wire PARITY_ERR, CRC_ERR, DM_ACTIVE, WDBI_ACTIVE, RDBI_ACTIVE, CMD_ACT_N, NOM_TERM_EN;
  wire [2:0] CMD_LINES, CMD_CODE;
  wire [17:0] ADDR, CMD_ADDR;
  wire [1:0] BA, BG, CMD_BA, CMD_BG;
  wire [3:0] WR_BURST_UI;
  integer fails = 0, cmp_count = 0, seen = 0;
  reg [17:0] last = 18'h0;
  reg [7:0] last_f = 8'h0;
  mr45_ctrl_model ctrl_i (
    .SYS_CLK(SYS_CLK), .CS_N(CS_N), .ACT_N(ACT_N), .CMD_LINES(CMD_LINES), .ADDR(ADDR), .BA(BA), .BG(BG),
    .PAR_IN(PAR_IN), .MRS_STROBE(MRS_STROBE)
  );
  mr45_feature_ctrl mr45_feature_ctrl_i (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .CS_N(CS_N), .ACT_N(ACT_N), .CMD_LINES(CMD_LINES), .ADDR(ADDR),
    .BA(BA), .BG(BG), .PAR_IN(PAR_IN), .IS_X4(IS_X4), .MRS_STROBE(MRS_STROBE), .MPS_EXIT(MPS_EXIT),
    .CRC_FAIL(CRC_FAIL), .POWER_DOWN(POWER_DOWN), .WRITE_BURST(WRITE_BURST), .ODT_PIN(ODT_PIN),
    .CMD_VALID(CMD_VALID), .CMD_ADDR(CMD_ADDR), .CMD_CODE(CMD_CODE), .CMD_ACT_N(CMD_ACT_N), .CMD_BA(CMD_BA),
    .CMD_BG(CMD_BG), .WPRE_2CK(WPRE_2CK), .RPRE_2CK(RPRE_2CK), .PRE_TRAIN(PRE_TRAIN), .TCR_ACTIVE(TCR_ACTIVE),
    .MPS_ACTIVE(MPS_ACTIVE), .PARITY_ERR(PARITY_ERR), .CRC_ERR(CRC_ERR), .DM_ACTIVE(DM_ACTIVE),
    .WDBI_ACTIVE(WDBI_ACTIVE), .RDBI_ACTIVE(RDBI_ACTIVE), .NOM_TERM_EN(NOM_TERM_EN), .WR_BURST_UI(WR_BURST_UI)
  );
  always #4 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    if (CMD_VALID === 1'b1) begin
      seen <= seen + 1;
      last <= CMD_ADDR;
      last_f <= {CMD_ACT_N, CMD_CODE, CMD_BG, CMD_BA};
    end
  end
  task chk(input [17:0] got, input [17:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // send one command and count the accepted pulses
  task go(input mode_register_set_cmd, input [2:0] sel, input [17:0] a, input flip, input [3:0] dly, input [17:0] expv);
    seen = 0;
    ctrl_i.send(mode_register_set_cmd, sel, a, flip, dly);
    repeat (12) @(negedge SYS_CLK);
    chk(seen, expv);
  endtask
  task tick(input integer n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task s_pre;
    ctrl_i.vref_settle(20, 1);
    go(1, 2, 18'h00008, 0, 0, 1);
    go(1, 4, 18'h01C00, 0, 0, 1);
    chk({WPRE_2CK, RPRE_2CK, PRE_TRAIN}, 3'h7);
    go(1, 7, 18'h00000, 0, 0, 0);
    chk({WPRE_2CK, RPRE_2CK, PRE_TRAIN}, 3'h7);
    go(1, 4, 18'h00000, 0, 0, 1);
    chk({WPRE_2CK, RPRE_2CK, PRE_TRAIN}, 3'h0);
  endtask
  task s_tcr_crc;
    go(1, 2, 18'h010C0, 0, 0, 1);
    go(1, 4, 18'h00008, 0, 0, 1);
    chk(TCR_ACTIVE, 1);
    chk(WR_BURST_UI, 4'hA);
    CRC_FAIL = 1'b1;
    tick(1);
    CRC_FAIL = 1'b0;
    tick(8);
    chk(CRC_ERR, 1);
    go(1, 5, 18'h00000, 0, 0, 1);
    chk(CRC_ERR, 0);
  endtask
  task s_par;
    go(0, 0, 18'h00123, 1, 0, 1);
    go(1, 5, 18'h00001, 0, 0, 1);
    go(0, 0, 18'h00123, 1, 0, 0);
    chk(PARITY_ERR, 1);
    go(0, 0, 18'h00055, 1, 0, 1);
    go(1, 5, 18'h00201, 0, 0, 1);
    chk(PARITY_ERR, 0);
    go(0, 0, 18'h00055, 1, 0, 0);
    go(0, 0, 18'h00055, 1, 0, 0);
    chk(PARITY_ERR, 1);
    go(1, 5, 18'h00000, 0, 0, 1);
  endtask
  task s_dbi;
    WRITE_BURST = 1'b1;
    go(1, 5, 18'h01C00, 0, 0, 1);
    chk({DM_ACTIVE, WDBI_ACTIVE, RDBI_ACTIVE}, 3'h3);
    IS_X4 = 1'b1;
    tick(8);
    chk({DM_ACTIVE, WDBI_ACTIVE, RDBI_ACTIVE}, 3'h0);
    IS_X4 = 1'b0;
    go(1, 5, 18'h00400, 0, 0, 1);
    chk({DM_ACTIVE, WDBI_ACTIVE, RDBI_ACTIVE}, 3'h4);
    WRITE_BURST = 1'b0;
    tick(4);
    chk(DM_ACTIVE, 0);
  endtask
  task s_odt;
    go(1, 1, 18'h00004, 0, 0, 1);
    ODT_PIN = 1'b1;
    tick(4);
    chk(NOM_TERM_EN, 1);
    POWER_DOWN = 1'b1;
    tick(4);
    chk(NOM_TERM_EN, 0);
    go(1, 5, 18'h00020, 0, 0, 1);
    chk(NOM_TERM_EN, 1);
    go(1, 1, 18'h00000, 0, 0, 1);
    chk(NOM_TERM_EN, 0);
    go(1, 5, 18'h00000, 0, 0, 1);
    go(1, 1, 18'h00004, 0, 0, 1);
    chk(NOM_TERM_EN, 1);
    {ODT_PIN, POWER_DOWN} = 2'h0;
  endtask
  task s_mps_cal;
    go(1, 4, 18'h00002, 0, 0, 1);
    go(0, 0, 18'h00010, 0, 0, 0);
    chk(MPS_ACTIVE, 1);
    MPS_EXIT = 1'b1;
    tick(1);
    MPS_EXIT = 1'b0;
    tick(8);
    chk(MPS_ACTIVE, 0);
    go(1, 4, 18'h00040, 0, 0, 1);
    go(0, 0, 18'h002A5, 0, 3, 1);
    chk(last, 18'h002A5);
    chk(last_f, 8'hD0);
    go(1, 4, 18'h00000, 0, 3, 1);
  endtask
  initial begin
    tick(2);
    NRST = 1'b1;
    tick(1);
    s_pre;
    s_tcr_crc;
    s_par;
    s_dbi;
    s_odt;
    s_mps_cal;
    results;
  end
endmodule
